// file: modem_ctl_regs.svh
// Purpose: Timing counts and codes of the modem handshake sequencer.
// Assumes: Included by bare name after the package.
// Notes: Definitions only.
`ifndef MODEM_CTL_REGS_SVH
`define MODEM_CTL_REGS_SVH
// Bits in one character on the line.
`define CHAR_BITS 4'd8
// Last bit count of a received character.
`define RX_LAST 3'd7
// End-of-transmission character sent by a tributary.
`define EOT_CODE 8'h04
// Idle marking level of the transmit data line.
`define TXD_MARK 1'b1
`endif

// file: modem_ctl_pkg.sv
// Purpose: Types shared by the sequencer and its line serdes.
// Assumes: Nothing beyond the constants header.
// Notes: All state travels as packed structs.
`default_nettype none
package modem_ctl_pkg;
	// Line arrangement chosen by the user.
	typedef enum logic [1:0] {
		MODE_LEASED    = 2'h0,
		MODE_POLL_CTRL = 2'h1,
		MODE_TRIB      = 2'h2,
		MODE_SWITCHED  = 2'h3
	} line_mode_t;
	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		S_OFF   = 6'h01,
		S_ARMED = 6'h02,
		S_RTS   = 6'h04,
		S_SEND  = 6'h08,
		S_TURN  = 6'h10,
		S_HUNG  = 6'h20
	} seq_state_t;
	// Status lines from the modem.
	typedef struct packed {
		logic dsr;
		logic cts;
		logic dcd;
		logic ri;
	} modem_in_t;
	// Control lines to the modem.
	typedef struct packed {
		logic dtr;
		logic rts;
	} modem_out_t;
	// Whole state of the sequencer.
	typedef struct packed {
		seq_state_t st;
		modem_in_t  pin_m;
		modem_in_t  pin_s;
		logic       ack_m;
		logic       ack_s;
		logic       ack_p;
		logic       rx_m;
		logic       rx_s;
		logic       rx_p;
		logic       req;
		logic [7:0] tx_byte;
		logic       tx_pend;
		logic       eot_q;
		logic       heard;
		logic       go;
		modem_out_t mo;
		logic [7:0] rx_data;
		logic       rx_valid;
	} seq_reg_t;
	// Whole state of the line serdes.
	typedef struct packed {
		logic       rst_m;
		logic       rst_s;
		logic       go_m;
		logic       go_s;
		logic       req_m;
		logic       req_s;
		logic       dcd_m;
		logic       dcd_s;
		logic       ack;
		logic       busy;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic       txd;
		logic [2:0] rx_cnt;
		logic [7:0] rx_sh;
		logic [7:0] rx_byte;
		logic       rx_tgl;
	} line_reg_t;
endpackage
`default_nettype wire

// file: line_serdes.sv
// Purpose: Bit serializer and deserializer on the modem's clock.
// Assumes: One modem clock times both transmit and receive data.
// Notes: Words cross to the system side by toggle handshakes.
`default_nettype none
`include "modem_ctl_regs.svh"
module line_serdes
	import modem_ctl_pkg::*;
(
	// Modem clock and the system-side reset.
	input  wire logic       line_clk,
	input  wire logic       rst_n,
	// Transmit handover from the sequencer.
	input  wire logic       go,
	input  wire logic       req_tgl,
	input  wire logic [7:0] tx_byte,
	output logic            ack_tgl,
	// Receive handover to the sequencer.
	output logic            rx_tgl,
	output logic [7:0]      rx_byte,
	// Modem pins.
	input  wire logic       dcd_pin,
	input  wire logic       rxd,
	output logic            txd
);
	line_reg_t  q;      // Registered state.
	line_reg_t  d;      // Next state.
	logic [7:0] rx_next; // Receive shifter after this bit.

	// Counter step of the transmit side only.
	function automatic logic [3:0] cnt_inc(input logic [3:0] c);
		cnt_inc = 4'(c + 4'h1);
	endfunction

	assign rx_next = {rxd, q.rx_sh[7:1]};

	////////////////////////////////////////////////////////////////////////
	// Next-state logic. The reset is resynchronised here because the
	// modem clock is unrelated to the system clock.
	always_comb
	begin
		d = q;
		d.rst_m = rst_n;
		d.rst_s = q.rst_m;
		d.go_m = go;
		d.go_s = q.go_m;
		d.req_m = req_tgl;
		d.req_s = q.req_m;
		d.dcd_m = dcd_pin;
		d.dcd_s = q.dcd_m;
		if (!q.rst_s)
		begin
			// Hold everything at rest, line marking.
			d.ack = 1'b0;
			d.busy = 1'b0;
			d.cnt = 4'h0;
			d.txd = `TXD_MARK;
			d.rx_cnt = 3'h0;
			d.rx_tgl = 1'b0;
		end
		else
		begin
			// Transmit side: one bit per modem clock, low bit first.
			if (q.busy && !q.go_s)
			begin
				// Clear to send lost: stop, mark, release the word.
				d.busy = 1'b0;
				d.txd = `TXD_MARK;
				d.ack = ~q.ack;
			end
			else if (q.busy && q.cnt == `CHAR_BITS)
			begin
				// Character done; a mark bit separates words.
				d.busy = 1'b0;
				d.txd = `TXD_MARK;
				d.ack = ~q.ack;
			end
			else if (q.busy)
			begin
				d.txd = q.sh[0];
				d.sh = q.sh >> 1;
				d.cnt = cnt_inc(q.cnt);
			end
			else if (q.req_s != q.ack && q.go_s)
			begin
				// Word is stable while the request is open.
				d.busy = 1'b1;
				d.txd = tx_byte[0];
				d.sh = tx_byte >> 1;
				d.cnt = 4'h1;
			end
			else if (q.req_s != q.ack)
			begin
				// No permission to send: drop the word, stay marking.
				d.ack = ~q.ack;
				d.txd = `TXD_MARK;
			end
			else
			begin
				d.txd = `TXD_MARK;
			end
			// Receive side: framing restarts with every carrier.
			if (!q.dcd_s)
			begin
				d.rx_cnt = 3'h0;
			end
			else
			begin
				d.rx_sh = rx_next;
				d.rx_cnt = 3'(q.rx_cnt + 3'h1);
				if (q.rx_cnt == `RX_LAST)
				begin
					d.rx_byte = rx_next;
					d.rx_tgl = ~q.rx_tgl;
				end
			end
		end
	end

	// State register on the modem clock.
	always_ff @(posedge line_clk)
	begin
		q <= d;
	end

	assign ack_tgl = q.ack;
	assign rx_tgl  = q.rx_tgl;
	assign rx_byte = q.rx_byte;
	assign txd     = q.txd;

	////////////////////////////////////////////////////////////////////////
	// Checks on the modem clock.
	default clocking cb @(posedge line_clk); endclocking
	default disable iff (!q.rst_s);

	a_txd_idle_mark: assert property (!q.go_s |=> q.txd)
		else $error("txd not marking without permission");
	a_tx_bit_order: assert property (
		(q.busy && q.go_s && q.cnt != `CHAR_BITS) |=> q.txd == $past(q.sh[0]))
		else $error("transmit bit out of order");
	a_rx_char_done: assert property (
		(q.dcd_s && q.rx_cnt == `RX_LAST) |=>
		(q.rx_tgl != $past(q.rx_tgl)) && q.rx_byte == $past(rx_next))
		else $error("received character not delivered");
endmodule
`default_nettype wire

// file: modem_control_handshake.sv
// Purpose: Terminal-side modem control sequencer with line serdes.
// Assumes: The modem keeps its carrier, delay and indication duties.
// Notes: Modem clock drives the serdes; the rest runs on ref_clk.
`default_nettype none
`include "modem_ctl_regs.svh"
module modem_control_handshake
	import modem_ctl_pkg::*;
(
	// System clock, reset and enable.
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// Modem clock, timing both data lines.
	input  wire logic        line_clk,
	// Modem pins.
	input  wire modem_in_t   mdm_in,
	input  wire logic        rxd,
	output modem_out_t       mdm_out,
	output logic             txd,
	// User control.
	input  wire logic        link_en,
	input  wire line_mode_t  mode,
	input  wire logic [7:0]  own_addr,
	input  wire logic        hang_up,
	// Transmit stream.
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	// Receive stream and line status.
	output logic [7:0]       rx_data,
	output logic             rx_valid,
	output logic             carrier_seen,
	output logic             ring_seen,
	output logic             modem_ready
);
	seq_reg_t   q;       // Registered state.
	seq_reg_t   d;       // Next state.
	logic       ack_tgl; // Word-done toggle from the serdes.
	logic       rx_tgl;  // Character toggle from the serdes.
	logic [7:0] rx_word; // Character held by the serdes.
	logic       ack_ev;  // Serdes finished a word.
	logic       rx_ev;   // Serdes delivered a character.
	logic       rx_hit;  // First character of a carrier is our address.
	logic       tx_take; // Word accepted from the stream.
	logic       tx_done; // Stream is empty and nothing is in flight.

	////////////////////////////////////////////////////////////////////////
	// Serdes on the modem clock.
	line_serdes u_serdes (
		.line_clk (line_clk),
		.rst_n    (rst_n),
		.go       (q.go),
		.req_tgl  (q.req),
		.tx_byte  (q.tx_byte),
		.ack_tgl  (ack_tgl),
		.rx_tgl   (rx_tgl),
		.rx_byte  (rx_word),
		.dcd_pin  (mdm_in.dcd),
		.rxd      (rxd),
		.txd      (txd)
	);

	// Events come from the second-stage flops only.
	assign ack_ev  = q.ack_s ^ q.ack_p;
	assign rx_ev   = q.rx_s ^ q.rx_p;
	assign rx_hit  = rx_ev && !q.heard && rx_word == own_addr
		&& mode == MODE_TRIB;
	// A word is taken only while the modem grants clear to send.
	assign tx_ready = q.st == S_SEND && q.pin_s.cts && !q.tx_pend
		&& !q.eot_q;
	assign tx_take = tx_valid && tx_ready;
	assign tx_done = !q.tx_pend && !tx_valid;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb
	begin
		d = q;
		// Two-flop synchronisers for pins and serdes toggles.
		d.pin_m = mdm_in;
		d.pin_s = q.pin_m;
		d.ack_m = ack_tgl;
		d.ack_s = q.ack_m;
		d.ack_p = q.ack_s;
		d.rx_m = rx_tgl;
		d.rx_s = q.rx_m;
		d.rx_p = q.rx_s;
		// The serdes holds the character for a whole character time,
		// far longer than the synchroniser delay, so it is stable here.
		d.rx_valid = rx_ev;
		if (rx_ev)
		begin
			d.rx_data = rx_word;
		end
		// Address match only counts on a carrier's first character.
		// The set wins: the last character and the carrier's end can
		// arrive in one cycle, and the clear follows a cycle later.
		if (rx_ev)
		begin
			d.heard = 1'b1;
		end
		else if (!q.pin_s.dcd)
		begin
			d.heard = 1'b0;
		end
		if (ack_ev)
		begin
			d.tx_pend = 1'b0;
		end
		if (tx_take)
		begin
			d.tx_byte = tx_data;
			d.tx_pend = 1'b1;
			d.req = ~q.req;
		end
		case (q.st)
			S_OFF:
			begin
				// Terminal ready comes first; in MODE_POLL_CTRL request to send rises with it.
				if (link_en)
				begin
					d.st = S_ARMED;
				end
			end
			S_ARMED:
			begin
				if (rx_hit)
				begin
					// Polled by our own address: ask to answer.
					d.st = S_RTS;
				end
				else if (mode == MODE_POLL_CTRL && tx_valid && q.pin_s.cts)
				begin
					// Carrier is up already; send without waiting.
					d.st = S_SEND;
				end
				else if (tx_valid && q.pin_s.dsr
					&& (mode == MODE_LEASED || mode == MODE_SWITCHED))
				begin
					d.st = S_RTS;
				end
			end
			S_RTS:
			begin
				// Hold request to send until the modem grants.
				if (q.pin_s.cts)
				begin
					d.st = S_SEND;
				end
			end
			S_SEND:
			begin
				if (!q.pin_s.cts)
				begin
					// Grant withdrawn: give up the turn.
					d.st = S_TURN;
				end
				else if (mode == MODE_TRIB && tx_done && !q.eot_q)
				begin
					// Response closes with end of transmission.
					d.tx_byte = `EOT_CODE;
					d.tx_pend = 1'b1;
					d.req = ~q.req;
					d.eot_q = 1'b1;
				end
				else if (mode == MODE_TRIB && q.eot_q && !q.tx_pend)
				begin
					d.st = S_TURN;
				end
				else if (mode != MODE_TRIB && tx_done)
				begin
					// Control station keeps its request up.
					d.st = (mode == MODE_POLL_CTRL) ? S_ARMED : S_TURN;
				end
			end
			S_TURN:
			begin
				// Wait for the modem to drop its grant before reuse.
				d.eot_q = 1'b0;
				if (!q.pin_s.cts && !q.tx_pend)
				begin
					d.st = S_ARMED;
				end
			end
			S_HUNG:
			begin
				// Stay off the line until the user lets go.
				if (!link_en)
				begin
					d.st = S_OFF;
				end
			end
			default:
			begin
				d.st = S_OFF;
			end
		endcase
		// Overrides: disconnect and disable win over everything.
		if (mode == MODE_SWITCHED && hang_up)
		begin
			d.st = S_HUNG;
		end
		else if (!link_en)
		begin
			d.st = S_OFF;
		end
		if (d.st == S_OFF || d.st == S_HUNG)
		begin
			d.eot_q = 1'b0;
		end
		// Pin levels follow the next state so they are registered.
		d.mo.dtr = d.st != S_OFF && d.st != S_HUNG;
		d.mo.rts = d.st == S_RTS || d.st == S_SEND
			|| (mode == MODE_POLL_CTRL && d.st == S_ARMED);
		// Serdes may shift only in the send state with a grant.
		d.go = d.st == S_SEND && q.pin_s.cts;
	end

	// State register; clk_en freezes the whole system-side state.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.st <= S_OFF;
		end
		else if (clk_en)
		begin
			q <= d;
		end
	end

	assign mdm_out      = q.mo;
	assign rx_data      = q.rx_data;
	assign rx_valid     = q.rx_valid;
	assign carrier_seen = q.pin_s.dcd;
	assign ring_seen    = q.pin_s.ri;
	assign modem_ready  = q.pin_s.dsr;

	////////////////////////////////////////////////////////////////////////
	// Checks on the system clock.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_leased_last;
		clk_en && link_en && mode == MODE_LEASED && q.st == S_SEND
			&& q.pin_s.cts && tx_done;
	endsequence
	sequence s_eot_acked;
		clk_en && link_en && !hang_up && mode == MODE_TRIB
			&& q.st == S_SEND && q.pin_s.cts && q.eot_q && !q.tx_pend;
	endsequence
	sequence s_trib_empty;
		clk_en && link_en && !hang_up && mode == MODE_TRIB
			&& q.st == S_SEND && q.pin_s.cts && tx_done && !q.eot_q;
	endsequence

	a_dtr_before_rts: assert property (mdm_out.rts |-> mdm_out.dtr)
		else $error("request to send without terminal ready");
	a_rts_drop_end: assert property (s_leased_last |=>
		!mdm_out.rts && q.st == S_TURN)
		else $error("request to send kept after transmission");
	a_ctrl_rts_hold: assert property (
		(mode == MODE_POLL_CTRL && q.st == S_ARMED) |-> mdm_out.rts)
		else $error("control station dropped request to send");
	a_poll_own_addr: assert property (
		(clk_en && link_en && mode == MODE_TRIB && q.st == S_ARMED)
		|=> ((q.st == S_RTS) == $past(rx_hit)))
		else $error("tributary answer not tied to own address");
	a_go_after_cts: assert property ($rose(q.go) |-> $past(q.pin_s.cts))
		else $error("transmit started without clear to send");
	a_eot_when_empty: assert property (s_trib_empty |=>
		q.tx_pend && q.tx_byte == `EOT_CODE ##1 q.eot_q)
		else $error("empty response not closed by end code");
	a_eot_then_drop: assert property (s_eot_acked |=>
		q.st == S_TURN && !mdm_out.rts)
		else $error("request kept after end code");
	a_answer_dtr: assert property (
		(clk_en && mode == MODE_SWITCHED && link_en && !hang_up && q.st == S_OFF)
		|=> mdm_out.dtr)
		else $error("answering terminal not ready");
	a_hang_drop_dtr: assert property (
		(clk_en && mode == MODE_SWITCHED && hang_up) |=> !mdm_out.dtr [*2])
		else $error("terminal ready kept after hang up");
endmodule
`default_nettype wire

// file: modem_partner.sv
// Purpose: Behavioural external modem facing the terminal sequencer.
// Assumes: The modem clock is made by the bench and runs free.
// Notes: Clear-to-send delay is an input, so tests can be prompt or slow.
`default_nettype none
module modem_partner
	import modem_ctl_pkg::*;
(
	// Clocks.
	input  wire logic       ref_clk,
	input  wire logic       line_clk,
	// Terminal side lines.
	input  wire modem_out_t mdm_out,
	output modem_in_t       mdm_in,
	output logic            rxd,
	// Bench controls.
	input  wire logic       dsr_on,
	input  wire logic       ring,
	input  wire logic [7:0] cts_dly
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ECHO_CYC = 8'h10; // Echo guard, scaled down to bench cycles.
	logic [7:0] echo_q = 8'h00; // Echo guard cycles still to run.
	logic [7:0] dly_q = 8'h00; // Cycles since request to send rose.
	logic       cts_q = 1'b0;  // Clear to send level.
	logic       dcd_q = 1'b0;  // Carrier detect level.
	initial rxd = 1'b1;
	// Status lines are driven straight, so carrier edges keep their line-clock phase.
	// Carrier is not passed on while the echo guard runs.
	always_comb
		mdm_in = '{dsr: dsr_on, cts: cts_q, dcd: dcd_q && echo_q == 8'h00, ri: ring};
	// Turning from transmitter to receiver starts the echo guard.
	always @(posedge ref_clk)
	begin
		if (mdm_out.rts)
			echo_q <= ECHO_CYC;
		else if (echo_q != 8'h00)
			echo_q <= echo_q - 8'h01;
	end
	// Clear to send follows request to send after a delay and drops with it.
	always @(posedge ref_clk)
	begin
		if (!mdm_out.rts)
		begin
			dly_q <= 8'h00;
			cts_q <= 1'b0;
		end
		else if (dly_q < cts_dly)
			dly_q <= dly_q + 8'h01;
		else
			cts_q <= 1'b1;
	end
	// Without carrier the data line toggles, so a stale level never passes for data.
	always @(posedge line_clk)
		if (!dcd_q)
			rxd <= ~rxd;
	// Sends one character under carrier, bit 0 first, two edges after carrier rises.
	// The far side holds off until the local echo guard is over.
	task automatic send_char(input logic [7:0] c);
		while (echo_q != 8'h00)
			@(posedge ref_clk);
		@(posedge line_clk);
		dcd_q <= 1'b1;
		repeat (2) @(posedge line_clk);
		for (int i = 0; i < 8; i++)
		begin
			rxd <= c[i];
			@(posedge line_clk);
		end
		dcd_q <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: modem_control_handshake_test.sv
// Purpose: Self-checking bench of the modem handshake sequencer.
// Assumes: Inputs change on the falling edge of ref_clk.
// Notes: Each line arrangement gets its own test task.
`default_nettype none
`include "modem_ctl_regs.svh"
`define CHECK(what, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("MISMATCH %s expected %h seen %h", what, exp, got); \
		end \
	end
module modem_control_handshake_test
	import modem_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk  = 1'b0;      // System clock, 20 ns.
	logic       line_clk = 1'b0;      // Modem clock, 30 ns.
	logic       rst_n    = 1'b0;      // Synchronous reset.
	logic       link_en  = 1'b0;      // Communications mode.
	line_mode_t mode     = MODE_LEASED; // Line arrangement.
	logic [7:0] own_addr = 8'h55;     // Tributary address.
	logic       hang_up  = 1'b0;      // Switched disconnect.
	logic [7:0] tx_data  = 8'h00;     // Transmit word.
	logic       tx_valid = 1'b0;      // Transmit request.
	logic       dsr_on   = 1'b1;      // Modem powered and connected.
	logic       ring     = 1'b0;      // Incoming call.
	logic [7:0] cts_dly  = 8'h02;     // Modem turn-on delay.
	logic       clk_en   = 1'b1;      // System-side clock enable.
	modem_in_t  mdm_in;
	modem_out_t mdm_out;
	logic       rxd, txd, tx_ready, rx_valid, ring_seen, carrier_seen, modem_ready;
	logic [7:0] rx_data;
	int         fail_count  = 0;
	int         checks_done = 0;
	// Clocks; the modem clock starts off-phase and stays unrelated.
	always #10 ref_clk = ~ref_clk;
	initial
	begin
		#3;
		forever #15 line_clk = ~line_clk;
	end
	modem_control_handshake u_modem_control_handshake (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .line_clk(line_clk),
		.mdm_in(mdm_in), .rxd(rxd), .mdm_out(mdm_out), .txd(txd),
		.link_en(link_en), .mode(mode), .own_addr(own_addr), .hang_up(hang_up),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .carrier_seen(carrier_seen),
		.ring_seen(ring_seen), .modem_ready(modem_ready));
	modem_partner u_modem_partner (
		.ref_clk(ref_clk), .line_clk(line_clk), .mdm_out(mdm_out), .mdm_in(mdm_in),
		.rxd(rxd), .dsr_on(dsr_on), .ring(ring), .cts_dly(cts_dly));
	// Picks a watched output by number, so one bounded wait serves them all.
	function automatic logic pick(input int s);
		case (s)
			0: return mdm_out.rts;
			1: return mdm_out.dtr;
			2: return carrier_seen;
			3: return rx_valid;
			default: return ring_seen;
		endcase
	endfunction
	task automatic await(input int s, input logic v, input int n);
		for (int i = 0; i < n && pick(s) !== v; i++)
			@(negedge ref_clk);
	endtask
	// Reset is held past three modem-clock edges so the serdes resets too.
	task automatic do_reset(input line_mode_t m);
		rst_n = 1'b0;
		mode = m;
		link_en = 1'b0;
		hang_up = 1'b0;
		tx_valid = 1'b0;
		ring = 1'b0;
		repeat (6) @(negedge ref_clk);
		`CHECK("reset rts", 1'b0, mdm_out.rts)
		`CHECK("reset tx_ready", 1'b0, tx_ready)
		`CHECK("reset txd", `TXD_MARK, txd)
		rst_n = 1'b1;
	endtask
	// Offers a word and holds it until the edge that takes it.
	task automatic send_byte(input logic [7:0] b);
		tx_data = b;
		tx_valid = 1'b1;
		for (int i = 0; i < 400 && tx_ready !== 1'b1; i++)
			@(negedge ref_clk);
		`CHECK("tx_ready", 1'b1, tx_ready)
		@(negedge ref_clk);
		tx_valid = 1'b0;
	endtask
	// Catches one word off the line from its first zero bit, plus the bit after it.
	task automatic get_tx(output logic [8:0] w);
		w = '1;
		for (int i = 0; i < 3000 && txd !== 1'b0; i++)
			@(negedge line_clk);
		for (int i = 0; i < 9; i++)
		begin
			w[i] = txd;
			@(negedge line_clk);
		end
	endtask
	task automatic test_leased();
		logic [8:0] w;
		dsr_on = 1'b0;
		cts_dly = 8'h28;
		do_reset(MODE_LEASED);
		link_en = 1'b1;
		repeat (3) @(negedge ref_clk);
		`CHECK("dtr up", 1'b1, mdm_out.dtr)
		fork
			send_byte(8'h5a);
			get_tx(w);
			begin
				repeat (10) @(negedge ref_clk);
				`CHECK("rts without dsr", 1'b0, mdm_out.rts)
				`CHECK("modem not ready", 1'b0, modem_ready)
				dsr_on = 1'b1;
			end
		join
		`CHECK("modem ready", 1'b1, modem_ready)
		`CHECK("tx word", 8'h5a, w[7:0])
		`CHECK("mark after word", `TXD_MARK, w[8])
		await(0, 1'b0, 400);
		`CHECK("rts dropped", 1'b0, mdm_out.rts)
		repeat (4) @(negedge line_clk);
		`CHECK("txd idle", `TXD_MARK, txd)
		$display("TEST leased done");
	endtask
	task automatic test_poll();
		logic [8:0] w;
		do_reset(MODE_POLL_CTRL);
		link_en = 1'b1;
		repeat (20) @(negedge ref_clk);
		`CHECK("poll rts", 1'b1, mdm_out.rts)
		repeat (60) @(negedge ref_clk);
		`CHECK("poll rts held", 1'b1, mdm_out.rts)
		fork
			send_byte(8'h3c);
			get_tx(w);
		join
		`CHECK("poll word", 8'h3c, w[7:0])
		`CHECK("poll mark", `TXD_MARK, w[8])
		repeat (10) @(negedge ref_clk);
		`CHECK("poll rts after word", 1'b1, mdm_out.rts)
		$display("TEST poll done");
	endtask
	task automatic test_trib();
		logic [8:0] w;
		cts_dly = 8'h02;
		do_reset(MODE_TRIB);
		link_en = 1'b1;
		u_modem_partner.send_char(8'h33);
		repeat (30) @(negedge ref_clk);
		`CHECK("foreign poll", 1'b0, mdm_out.rts)
		`CHECK("carrier gone", 1'b0, carrier_seen)
		fork
			u_modem_partner.send_char(8'h55);
			get_tx(w);
		join
		`CHECK("eot word", `EOT_CODE, w[7:0])
		`CHECK("eot mark", `TXD_MARK, w[8])
		await(0, 1'b0, 200);
		`CHECK("rts after eot", 1'b0, mdm_out.rts)
		u_modem_partner.send_char(8'h55);
		await(0, 1'b1, 100);
		`CHECK("second poll", 1'b1, mdm_out.rts)
		$display("TEST tributary done");
	endtask
	task automatic test_switched();
		do_reset(MODE_SWITCHED);
		clk_en = 1'b0;
		ring = 1'b1;
		repeat (5) @(negedge ref_clk);
		`CHECK("ring frozen", 1'b0, ring_seen)
		clk_en = 1'b1;
		await(4, 1'b1, 20);
		`CHECK("ring seen", 1'b1, ring_seen)
		link_en = 1'b1;
		await(1, 1'b1, 10);
		`CHECK("answer dtr", 1'b1, mdm_out.dtr)
		ring = 1'b0;
		fork
			u_modem_partner.send_char(8'h3c);
			await(3, 1'b1, 200);
			begin
				await(2, 1'b1, 100);
				`CHECK("carrier seen", 1'b1, carrier_seen)
			end
		join
		`CHECK("rx word", 8'h3c, rx_data)
		hang_up = 1'b1;
		await(1, 1'b0, 10);
		`CHECK("hang up dtr", 1'b0, mdm_out.dtr)
		repeat (10) @(negedge ref_clk);
		`CHECK("dtr stays off", 1'b0, mdm_out.dtr)
		$display("TEST switched done");
	endtask
	task automatic tally_and_finish();
		$display("COUNTS checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		test_leased();
		test_poll();
		test_trib();
		test_switched();
		tally_and_finish();
	end
	// The tests need well under a tenth of this span.
	initial
	begin
		#1000000;
		fail_count++;
		$display("TIMEOUT watchdog expired");
		tally_and_finish();
	end
endmodule
`default_nettype wire
